/* src/gsioc_pkg.sv */
// Constants shared by the global status and IO configuration block.
package gsioc_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [6:0] OFS_GLOBAL_STATUS = 7'h01;
   localparam logic [6:0] OFS_WRITE_TALLY = 7'h02;
   localparam logic [6:0] OFS_NODE_SETUP = 7'h03;
   localparam logic [6:0] OFS_PIN_READBACK = 7'h04;
   localparam logic [6:0] OFS_IO_OUTPUT = 7'h04;
   localparam logic [6:0] OFS_POS_MATCH = 7'h05;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int STAT_RESET_BIT = 0;
   localparam int STAT_DRV1_BIT = 1;
   localparam int STAT_DRV2_BIT = 2;
   localparam int STAT_PUMP_UV_BIT = 3;
   localparam int NODE_ADDR_LSB = 0;
   localparam int NODE_ADDR_MSB = 7;
   localparam int REPLY_DELAY_LSB = 8;
   localparam int REPLY_DELAY_MSB = 11;
   localparam int IO_LEVEL_LSB = 0;
   localparam int IO_LEVEL_MSB = 2;
   localparam int IO_DIR_LSB = 8;
   localparam int IO_DIR_MSB = 10;
   localparam int RB_LINE_P_BIT = 4;
   localparam int RB_LINE_N_BIT = 5;
   localparam int RB_COMP_BIT = 8;
   localparam int RB_VERSION_LSB = 24;
   localparam int RB_VERSION_MSB = 31;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [3:0] GLOBAL_STATUS_RESET = 4'h1;
   localparam logic [7:0] WRITE_TALLY_RESET = 8'h00;
   localparam logic [11:0] NODE_SETUP_RESET = 12'h000;
   localparam logic [11:0] IO_OUTPUT_RESET = 12'h000;
   localparam logic [31:0] POS_MATCH_RESET = 32'h0000_0000;
   localparam logic [31:0] READ_DATA_RESET = 32'h0000_0000;
   localparam logic [7:0] NODE_ADDR_ZERO = 8'h00;

   // ---------------------------------------------------------------
   // Identification and sizes
   // ---------------------------------------------------------------
   // Arbitrary silicon version code.
   localparam logic [7:0] SILICON_VERSION = 8'h3C;
   localparam int SYNC_WIDTH = 14;
endpackage

/* src/gsioc_sync.sv */
// Two-stage synchroniser for asynchronous pin levels.
`timescale 1ns/1ps
`default_nettype none
module gsioc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync_out;

   always_comb begin
      next_stage1 = async_in;
      next_sync_out = stage1;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= next_stage1;
         sync_out <= next_sync_out;
      end
   end
endmodule
`default_nettype wire

/* src/gsioc_poscmp.sv */
// Position comparator that drives the position pulse.
`timescale 1ns/1ps
`default_nettype none
module gsioc_poscmp (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic signed [31:0] current_position,
   input wire logic signed [31:0] match_value,
   input wire logic pulse_select,
   output logic pulse_out
);
   logic next_pulse_out;

   // Evaluated every clock so the pulse follows the position within one cycle.
   always_comb begin
      next_pulse_out = pulse_select && (current_position == match_value);
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pulse_out <= 1'b0;
      end else begin
         pulse_out <= next_pulse_out;
      end
   end
endmodule
`default_nettype wire

/* src/gsioc_top.sv */
// Global status, write tally, node setup, pin read-back and IO configuration registers.
`timescale 1ns/1ps
`default_nettype none
module gsioc_top (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [6:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   input wire logic uart_mode,
   input wire logic uart_write_ok,
   input wire logic ring_mode,
   input wire logic poscmp_enable,
   input wire logic signed [31:0] current_position,
   input wire logic drv1_overtemp,
   input wire logic drv1_short,
   input wire logic drv2_overtemp,
   input wire logic drv2_short,
   input wire logic pump_undervoltage,
   input wire logic [3:0] gp_pin_in,
   input wire logic line_p_in,
   input wire logic line_n_in,
   input wire logic line_comp_in,
   input wire logic addr_step_in,
   input wire logic drv_enable_pin_n_in,
   output logic [2:0] gp_pin_out,
   output logic [2:0] gp_pin_oe,
   output logic [7:0] node_address_eff,
   output logic forward_enable,
   output logic [6:0] reply_delay_bits,
   output logic line_drive_allow,
   output logic drv1_enable,
   output logic drv2_enable,
   output logic position_pulse_pin,
   output logic int_pin_select,
   output logic enc1_select
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // A fault flag is set while its condition holds, and a read clears it only once the condition is gone.
   function automatic logic sticky_next(input logic flag, input logic cond, input logic rd_clear);
      sticky_next = cond | (flag & ~rd_clear);
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   logic [13:0] pins_async;
   logic [13:0] pins_sync;
   logic [3:0] gp_sync;
   logic line_p_sync;
   logic line_n_sync;
   logic comp_sync;
   logic addr_step_sync;
   logic drv_enn_sync;
   logic drv1_cond;
   logic drv2_cond;
   logic uv_sync;

   assign pins_async = {pump_undervoltage, drv2_short, drv2_overtemp, drv1_short, drv1_overtemp,
                        drv_enable_pin_n_in, addr_step_in, line_comp_in, line_n_in, line_p_in, gp_pin_in};

   gsioc_sync #(
      .WIDTH(gsioc_pkg::SYNC_WIDTH)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .async_in(pins_async),
      .sync_out(pins_sync)
   );

   assign gp_sync = pins_sync[3:0];
   assign line_p_sync = pins_sync[4];
   assign line_n_sync = pins_sync[5];
   assign comp_sync = pins_sync[6];
   assign addr_step_sync = pins_sync[7];
   assign drv_enn_sync = pins_sync[8];
   assign drv1_cond = pins_sync[9] | pins_sync[10];
   assign drv2_cond = pins_sync[11] | pins_sync[12];
   assign uv_sync = pins_sync[13];

   // ---------------------------------------------------------------
   // Access decode
   // ---------------------------------------------------------------
   logic rd_status;
   logic wr_node;
   logic wr_io;
   logic wr_match;

   assign rd_status = reg_rd_en && (reg_addr == gsioc_pkg::OFS_GLOBAL_STATUS);
   assign wr_node = reg_wr_en && (reg_addr == gsioc_pkg::OFS_NODE_SETUP);
   assign wr_io = reg_wr_en && (reg_addr == gsioc_pkg::OFS_IO_OUTPUT);
   assign wr_match = reg_wr_en && (reg_addr == gsioc_pkg::OFS_POS_MATCH);

   // ---------------------------------------------------------------
   // Global status flags
   // ---------------------------------------------------------------
   logic [3:0] global_status_flags;
   logic [3:0] next_global_status_flags;

   always_comb begin
      next_global_status_flags = global_status_flags;
      // Reset value is 1, so the flag shows a reset until the first status read.
      next_global_status_flags[gsioc_pkg::STAT_RESET_BIT] =
         global_status_flags[gsioc_pkg::STAT_RESET_BIT] & ~rd_status;
      next_global_status_flags[gsioc_pkg::STAT_DRV1_BIT] =
         sticky_next(global_status_flags[gsioc_pkg::STAT_DRV1_BIT], drv1_cond, rd_status);
      next_global_status_flags[gsioc_pkg::STAT_DRV2_BIT] =
         sticky_next(global_status_flags[gsioc_pkg::STAT_DRV2_BIT], drv2_cond, rd_status);
      next_global_status_flags[gsioc_pkg::STAT_PUMP_UV_BIT] =
         sticky_next(global_status_flags[gsioc_pkg::STAT_PUMP_UV_BIT], uv_sync, rd_status);
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         global_status_flags <= gsioc_pkg::GLOBAL_STATUS_RESET;
      end else begin
         global_status_flags <= next_global_status_flags;
      end
   end

   // ---------------------------------------------------------------
   // UART write tally
   // ---------------------------------------------------------------
   logic [7:0] uart_write_tally;
   logic [7:0] next_uart_write_tally;

   always_comb begin
      next_uart_write_tally = uart_write_tally;
      if (uart_mode && uart_write_ok) begin
         next_uart_write_tally = uart_write_tally + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         uart_write_tally <= gsioc_pkg::WRITE_TALLY_RESET;
      end else begin
         uart_write_tally <= next_uart_write_tally;
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic [11:0] node_setup;
   logic [11:0] io_output_control;
   logic signed [31:0] position_match_value;
   logic [11:0] next_node_setup;
   logic [11:0] next_io_output_control;
   logic signed [31:0] next_position_match_value;

   always_comb begin
      next_node_setup = node_setup;
      next_io_output_control = io_output_control;
      next_position_match_value = position_match_value;
      if (wr_node) begin
         next_node_setup = reg_wdata[11:0];
      end
      if (wr_io) begin
         next_io_output_control = reg_wdata[11:0];
      end
      if (wr_match) begin
         next_position_match_value = reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         node_setup <= gsioc_pkg::NODE_SETUP_RESET;
         io_output_control <= gsioc_pkg::IO_OUTPUT_RESET;
         position_match_value <= gsioc_pkg::POS_MATCH_RESET;
      end else begin
         node_setup <= next_node_setup;
         io_output_control <= next_io_output_control;
         position_match_value <= next_position_match_value;
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   logic [31:0] pin_readback;
   logic [31:0] next_reg_rdata;

   always_comb begin
      pin_readback = gsioc_pkg::READ_DATA_RESET;
      // IO pins read back from the pads, so driven outputs show too.
      pin_readback[3:0] = gp_sync;
      pin_readback[gsioc_pkg::RB_LINE_P_BIT] = line_p_sync;
      pin_readback[gsioc_pkg::RB_LINE_N_BIT] = line_n_sync;
      pin_readback[6] = addr_step_sync;
      pin_readback[7] = drv_enn_sync;
      pin_readback[gsioc_pkg::RB_COMP_BIT] = comp_sync;
      pin_readback[gsioc_pkg::RB_VERSION_MSB:gsioc_pkg::RB_VERSION_LSB] = gsioc_pkg::SILICON_VERSION;
   end

   always_comb begin
      next_reg_rdata = reg_rdata;
      if (reg_rd_en) begin
         case (reg_addr)
            gsioc_pkg::OFS_GLOBAL_STATUS: begin
               next_reg_rdata = {28'h000_0000, global_status_flags};
            end
            gsioc_pkg::OFS_WRITE_TALLY: begin
               next_reg_rdata = {24'h00_0000, uart_write_tally};
            end
            gsioc_pkg::OFS_PIN_READBACK: begin
               next_reg_rdata = pin_readback;
            end
            default: begin
               next_reg_rdata = gsioc_pkg::READ_DATA_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= gsioc_pkg::READ_DATA_RESET;
      end else begin
         reg_rdata <= next_reg_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   logic [7:0] node_address;
   logic [3:0] reply_delay;
   logic [2:0] next_gp_pin_out;
   logic [2:0] next_gp_pin_oe;
   logic [7:0] next_node_address_eff;
   logic next_forward_enable;
   logic [6:0] next_reply_delay_bits;
   logic next_line_drive_allow;
   logic next_drv1_enable;
   logic next_drv2_enable;
   logic next_int_pin_select;
   logic next_enc1_select;

   assign node_address = node_setup[gsioc_pkg::NODE_ADDR_MSB:gsioc_pkg::NODE_ADDR_LSB];
   assign reply_delay = node_setup[gsioc_pkg::REPLY_DELAY_MSB:gsioc_pkg::REPLY_DELAY_LSB];

   always_comb begin
      // IO pin 3 has no driver; bits 3 and 11 are stored but unused.
      next_gp_pin_out = io_output_control[gsioc_pkg::IO_LEVEL_MSB:gsioc_pkg::IO_LEVEL_LSB];
      next_gp_pin_oe = io_output_control[gsioc_pkg::IO_DIR_MSB:gsioc_pkg::IO_DIR_LSB];
      next_node_address_eff = node_address + {7'h00, addr_step_sync};
      next_forward_enable = !(ring_mode && (node_address == gsioc_pkg::NODE_ADDR_ZERO));
      // Odd multiple of eight: codes 2n and 2n+1 both give (2n+1)*8 bit times.
      next_reply_delay_bits = {reply_delay[3:1], 1'b1, 3'h0};
      next_line_drive_allow = uart_mode;
      next_drv1_enable = !uv_sync && !drv1_cond;
      next_drv2_enable = !uv_sync && !drv2_cond;
      next_int_pin_select = poscmp_enable;
      next_enc1_select = !poscmp_enable;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         gp_pin_out <= 3'h0;
         gp_pin_oe <= 3'h0;
         node_address_eff <= gsioc_pkg::NODE_ADDR_ZERO;
         forward_enable <= 1'b1;
         reply_delay_bits <= 7'h08;
         line_drive_allow <= 1'b0;
         drv1_enable <= 1'b0;
         drv2_enable <= 1'b0;
         int_pin_select <= 1'b0;
         enc1_select <= 1'b1;
      end else begin
         gp_pin_out <= next_gp_pin_out;
         gp_pin_oe <= next_gp_pin_oe;
         node_address_eff <= next_node_address_eff;
         forward_enable <= next_forward_enable;
         reply_delay_bits <= next_reply_delay_bits;
         line_drive_allow <= next_line_drive_allow;
         drv1_enable <= next_drv1_enable;
         drv2_enable <= next_drv2_enable;
         int_pin_select <= next_int_pin_select;
         enc1_select <= next_enc1_select;
      end
   end

   // ---------------------------------------------------------------
   // Position comparator
   // ---------------------------------------------------------------
   gsioc_poscmp u_poscmp (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .current_position(current_position),
      .match_value(position_match_value),
      .pulse_select(poscmp_enable),
      .pulse_out(position_pulse_pin)
   );
endmodule
`default_nettype wire

/* test/gsioc_checker.sv */
// Concurrent checks on the ports of the global status and IO configuration block.
`timescale 1ns/1ps
`default_nettype none
module gsioc_checker (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [6:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic uart_mode,
   input wire logic uart_write_ok,
   input wire logic ring_mode,
   input wire logic poscmp_enable,
   input wire logic signed [31:0] current_position,
   input wire logic pump_undervoltage,
   input wire logic [2:0] gp_pin_out,
   input wire logic [2:0] gp_pin_oe,
   input wire logic forward_enable,
   input wire logic [6:0] reply_delay_bits,
   input wire logic drv1_enable,
   input wire logic drv2_enable,
   input wire logic position_pulse_pin,
   input wire logic int_pin_select,
   input wire logic enc1_select
);
   logic [31:0] match_sh;
   logic [11:0] node_sh;
   logic [11:0] io_sh;
   logic [7:0] tally_sh;
   logic rst_flag;
   logic hit;
   logic fwd_exp;
   logic [6:0] delay_exp;
   logic [5:0] io_view;

   // Shadow copies of the register state follow the same strobes as the block.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         match_sh <= gsioc_pkg::POS_MATCH_RESET;
         node_sh <= gsioc_pkg::NODE_SETUP_RESET;
         io_sh <= gsioc_pkg::IO_OUTPUT_RESET;
         tally_sh <= gsioc_pkg::WRITE_TALLY_RESET;
         rst_flag <= 1'b1;
      end else begin
         if (reg_wr_en && reg_addr == gsioc_pkg::OFS_POS_MATCH) match_sh <= reg_wdata;
         if (reg_wr_en && reg_addr == gsioc_pkg::OFS_NODE_SETUP) node_sh <= reg_wdata[11:0];
         if (reg_wr_en && reg_addr == gsioc_pkg::OFS_IO_OUTPUT) io_sh <= reg_wdata[11:0];
         if (uart_mode && uart_write_ok) tally_sh <= tally_sh + 8'h01;
         if (reg_rd_en && reg_addr == gsioc_pkg::OFS_GLOBAL_STATUS) rst_flag <= 1'b0;
      end
   end

   assign hit = poscmp_enable && (current_position == match_sh);
   assign fwd_exp = !(ring_mode && node_sh[7:0] == 8'h00);
   assign delay_exp = {3'h0, node_sh[11:8] | 4'h1} * 7'h08;
   assign io_view = {io_sh[10:8], io_sh[2:0] & io_sh[10:8]};

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   pulse_follow_a: assert property ($past(rst_b) |-> position_pulse_pin == $past(hit))
      else $error("position pulse does not follow the match");
   pin_route_a: assert property ($past(rst_b) |-> int_pin_select == $past(poscmp_enable) && enc1_select == !int_pin_select)
      else $error("pulse pin routing wrong");
   delay_code_a: assert property ($past(rst_b) |-> reply_delay_bits == $past(delay_exp))
      else $error("reply delay wrong");
   fwd_gate_a: assert property ($past(rst_b) |-> forward_enable == $past(fwd_exp))
      else $error("forwarding gate wrong");
   io_config_a: assert property ($past(rst_b) |-> {gp_pin_oe, gp_pin_out & gp_pin_oe} == $past(io_view))
      else $error("IO direction or level wrong");
   tally_read_a: assert property (reg_rd_en && reg_addr == gsioc_pkg::OFS_WRITE_TALLY |=>
      reg_rdata == {24'h00_0000, $past(tally_sh)}) else $error("write tally read wrong");
   status_read_a: assert property (reg_rd_en && reg_addr == gsioc_pkg::OFS_GLOBAL_STATUS |=>
      reg_rdata[31:4] == 28'h000_0000 && reg_rdata[0] == $past(rst_flag)) else $error("status read wrong");
   version_read_a: assert property (reg_rd_en && reg_addr == gsioc_pkg::OFS_PIN_READBACK |=>
      reg_rdata[31:24] == gsioc_pkg::SILICON_VERSION && reg_rdata[23:9] == 15'h0000) else $error("version wrong");
   uv_disable_a: assert property (pump_undervoltage [*4] |-> !drv1_enable && !drv2_enable)
      else $error("drivers enabled under pump undervoltage");
endmodule

bind gsioc_top gsioc_checker chk (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
   .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .uart_mode(uart_mode),
   .uart_write_ok(uart_write_ok), .ring_mode(ring_mode), .poscmp_enable(poscmp_enable),
   .current_position(current_position), .pump_undervoltage(pump_undervoltage), .gp_pin_out(gp_pin_out),
   .gp_pin_oe(gp_pin_oe), .forward_enable(forward_enable), .reply_delay_bits(reply_delay_bits),
   .drv1_enable(drv1_enable), .drv2_enable(drv2_enable), .position_pulse_pin(position_pulse_pin),
   .int_pin_select(int_pin_select), .enc1_select(enc1_select));
`default_nettype wire

/* test/gsioc_host_model.sv */
// Host-side register access model for the global status and IO block.
`timescale 1ns/1ps
`default_nettype none
module gsioc_host_model (
   input wire logic ref_clk,
   input wire logic [31:0] reg_rdata,
   output logic [6:0] reg_addr,
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [31:0] reg_wdata
);
   initial begin
      reg_addr = 7'h00;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_wdata = 32'h0000_0000;
   end

   // Each access holds one taking edge, then scrambles the released lines.
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge ref_clk);
      reg_wr_en = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [6:0] a, output logic [31:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge ref_clk);
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking testbench for the global status and IO configuration block.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [6:0] A_ST = gsioc_pkg::OFS_GLOBAL_STATUS;
   localparam logic [6:0] A_TY = gsioc_pkg::OFS_WRITE_TALLY;
   localparam logic [6:0] A_RB = gsioc_pkg::OFS_PIN_READBACK;
   logic ref_clk, rst_b, reg_wr_en, reg_rd_en, uart_mode, uart_write_ok, ring_mode, poscmp_enable;
   logic drv1_overtemp, drv1_short, drv2_overtemp, drv2_short, pump_undervoltage;
   logic line_p_in, line_n_in, line_comp_in, addr_step_in, drv_enable_pin_n_in;
   logic forward_enable, line_drive_allow, drv1_enable, drv2_enable, position_pulse_pin, int_pin_select, enc1_select;
   logic [2:0] gp_pin_out, gp_pin_oe;
   logic [3:0] gp_pin_in, gp_drv;
   logic [6:0] reg_addr, reply_delay_bits;
   logic [7:0] node_address_eff, a;
   logic [8:0] p;
   logic [31:0] reg_wdata, reg_rdata, rd_val;
   logic signed [31:0] current_position;
   int n_errors, n_compared;

   // Pins 0 to 2 carry the block's own level while it drives them.
   assign gp_pin_in = {gp_drv[3], (gp_pin_oe & gp_pin_out) | (~gp_pin_oe & gp_drv[2:0])};

   gsioc_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .uart_mode(uart_mode),
      .uart_write_ok(uart_write_ok), .ring_mode(ring_mode), .poscmp_enable(poscmp_enable),
      .current_position(current_position), .drv1_overtemp(drv1_overtemp), .drv1_short(drv1_short),
      .drv2_overtemp(drv2_overtemp), .drv2_short(drv2_short), .pump_undervoltage(pump_undervoltage),
      .gp_pin_in(gp_pin_in), .line_p_in(line_p_in), .line_n_in(line_n_in), .line_comp_in(line_comp_in),
      .addr_step_in(addr_step_in), .drv_enable_pin_n_in(drv_enable_pin_n_in), .gp_pin_out(gp_pin_out),
      .gp_pin_oe(gp_pin_oe), .node_address_eff(node_address_eff), .forward_enable(forward_enable),
      .reply_delay_bits(reply_delay_bits), .line_drive_allow(line_drive_allow), .drv1_enable(drv1_enable),
      .drv2_enable(drv2_enable), .position_pulse_pin(position_pulse_pin), .int_pin_select(int_pin_select),
      .enc1_select(enc1_select));
   gsioc_host_model host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic rdc(input logic [6:0] ad, input logic [31:0] exp);
      host.rd(ad, rd_val);
      chk(rd_val, exp);
   endtask

   task automatic faults(input logic [4:0] f);
      {pump_undervoltage, drv2_short, drv2_overtemp, drv1_short, drv1_overtemp} = f;
      tick(4);
   endtask

   task automatic pulses(input int n);
      uart_write_ok = 1'b1;
      tick(n);
      uart_write_ok = 1'b0;
   endtask

   task automatic t_faults;
      logic [31:0] e;
      for (int i = 0; i < 5; i++) begin
         e = (i < 2) ? 32'h0000_0002 : ((i < 4) ? 32'h0000_0004 : 32'h0000_0008);
         faults(5'(1 << i));
         chk({30'h0, drv2_enable, drv1_enable}, {30'h0, (i < 2), (i == 2 || i == 3)});
         rdc(A_ST, e);
         rdc(A_ST, e);
         faults(5'h00);
         chk({30'h0, drv2_enable, drv1_enable}, 32'h0000_0003);
         rdc(A_ST, e);
         rdc(A_ST, 32'h0000_0000);
      end
   endtask

   task automatic t_tally;
      pulses(255);
      rdc(A_TY, 32'h0000_00FF);
      rdc(A_TY, 32'h0000_00FF);
      uart_mode = 1'b0;
      pulses(3);
      rdc(A_TY, 32'h0000_00FF);
      uart_mode = 1'b1;
      host.wr(A_TY, 32'h0000_0000);
      pulses(1);
      rdc(A_TY, 32'h0000_0000);
   endtask

   // All 16 reply delay codes are written, from the shortest delay to the longest.
   task automatic t_node;
      for (int c = 0; c < 16; c++) begin
         a = 8'(c * 13);
         ring_mode = ~c[0];
         host.wr(gsioc_pkg::OFS_NODE_SETUP, {20'h0_0000, 4'(c), a});
         tick(2);
         chk({25'h000_0000, reply_delay_bits}, 32'((c | 1) * 8));
         chk({24'h00_0000, node_address_eff}, {24'h00_0000, a});
         chk({31'h0, forward_enable}, {31'h0, (c != 0)});
      end
      addr_step_in = 1'b1;
      tick(4);
      chk({24'h00_0000, node_address_eff}, 32'h0000_00C4);
      rdc(gsioc_pkg::OFS_NODE_SETUP, 32'h0000_0000);
      rdc(7'h06, 32'h0000_0000);
   endtask

   task automatic t_pins;
      uart_mode = 1'b0;
      for (int k = 0; k < 3; k++) begin
         p = (k == 0) ? 9'h155 : ((k == 1) ? 9'h0AA : 9'h000);
         {line_comp_in, drv_enable_pin_n_in, addr_step_in, line_n_in, line_p_in, gp_drv} = p;
         tick(4);
         rdc(A_RB, {gsioc_pkg::SILICON_VERSION, 15'h0000, p});
         chk({30'h0, rd_val[5:4]}, {30'h0, p[5:4]});
         chk({31'h0, rd_val[8]}, {31'h0, p[8]});
         chk({24'h00_0000, rd_val[31:24]}, {24'h00_0000, gsioc_pkg::SILICON_VERSION});
         chk({31'h0, line_drive_allow}, 32'h0000_0000);
      end
      uart_mode = 1'b1;
      tick(2);
      chk({31'h0, line_drive_allow}, 32'h0000_0001);
   endtask

   task automatic t_io;
      gp_drv = 4'h8;
      host.wr(gsioc_pkg::OFS_IO_OUTPUT, 32'h0000_0D0B);
      tick(2);
      chk({29'h0, gp_pin_oe}, 32'h0000_0005);
      chk({29'h0, gp_pin_out & gp_pin_oe}, 32'h0000_0001);
      tick(2);
      rdc(A_RB, {gsioc_pkg::SILICON_VERSION, 24'h00_0009});
      host.wr(gsioc_pkg::OFS_IO_OUTPUT, 32'h0000_0704);
      tick(2);
      chk({29'h0, gp_pin_out}, 32'h0000_0004);
      host.wr(gsioc_pkg::OFS_IO_OUTPUT, 32'h0000_0000);
      tick(2);
      chk({29'h0, gp_pin_oe}, 32'h0000_0000);
   endtask

   task automatic t_pos;
      current_position = 32'hFFFF_FFF0;
      host.wr(gsioc_pkg::OFS_POS_MATCH, 32'hFFFF_FFF0);
      tick(2);
      chk({29'h0, position_pulse_pin, int_pin_select, enc1_select}, 32'h0000_0001);
      poscmp_enable = 1'b1;
      tick(2);
      chk({29'h0, position_pulse_pin, int_pin_select, enc1_select}, 32'h0000_0006);
      current_position = 32'hFFFF_FFF1;
      tick(1);
      chk({31'h0, position_pulse_pin}, 32'h0000_0000);
      current_position = 32'hFFFF_FFF0;
      tick(1);
      chk({31'h0, position_pulse_pin}, 32'h0000_0001);
   endtask

   task automatic t_reset;
      rdc(A_ST, 32'h0000_0001);
      host.wr(A_ST, 32'h0000_000F);
      rdc(A_ST, 32'h0000_0000);
      rdc(A_TY, 32'h0000_0000);
      chk({24'h00_0000, node_address_eff}, 32'h0000_0000);
      chk({25'h000_0000, reply_delay_bits}, 32'h0000_0008);
   endtask

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      n_errors = 0;
      n_compared = 0;
      {rst_b, uart_write_ok, ring_mode, poscmp_enable, line_p_in, line_n_in, line_comp_in} = 7'h00;
      {addr_step_in, drv_enable_pin_n_in, gp_drv, current_position} = 38'h0;
      uart_mode = 1'b1;
      faults(5'h00);
      rst_b = 1'b1;
      t_reset;
      t_faults;
      t_tally;
      t_node;
      t_pins;
      t_io;
      t_pos;
      rst_b = 1'b0;
      tick(2);
      rst_b = 1'b1;
      t_reset;
      end_of_test;
   end

   initial begin
      #2000000;
      n_errors++;
      end_of_test;
   end
endmodule
`default_nettype wire
